// *** bcte_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bcte_defines.svh"
// Summary of operation
// RQ1: Pair immediate load writes eight bits into a register pair.
// RQ2: Pair table read loads page and pointer addressed word into chosen pair.
// RQ3: Table address: page register gives top bits, pointer pair the rest.
// RQ4: Program memory uses 1K pages; only pages 0 and 1 are targets.
// RQ5: Jump on carry set loads target, else PC advances by two.
// RQ6: Jump on carry clear loads target, else PC advances by two.
// RQ7: Jump on status set loads target, else PC advances by two.
// RQ8: Jump on status clear loads target, else PC advances by two.
// RQ9: Target bits in second word ordered a9 a7 a6 a5 a4 a8 a3..a0.
// RQ10: Call bumps stack pointer, saves PC plus two in return store, then jumps.
// RQ11: Stack pointer carry on call forces an internal reset.
// RQ12: Return copies return store into PC, then drops stack pointer.
// RQ13: Stack pointer borrow on return forces an internal reset.
// RQ14: Timer nibble reads give t9..t6 high and t5..t2 low.
// RQ15: Modulo nibble reads use the timer mapping and clear carry.
// RQ16: Timer nibble writes also clear t1 (high) or t0 (low).
// RQ17: Modulo nibble writes clear carry and clear t1 or t0.
// RQ18: Timer immediate layout is t1 t9 t8 t7 t6 t0 t5..t2.
// RQ19: Timer interval is (value plus one) times 64 minus 4 clocks.
// RQ20: Modulo immediate loads write all ten bits, timer layout.
// RQ21: Timer and modulo table loads copy the whole ten-bit word.
// RQ22: Halt enters standby; its operand picks the release conditions.
// RQ23: Flags untouched unless named; each instruction is one step.
module bcte_core
  import bcte_pkg::*;
#(
  parameter int ROM_AW = 11,
  parameter int SP_W = 1
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] wake_i,
  output logic standby_o,
  output logic timer_evt_o,
  output logic core_reset_o
);
  localparam int PG_W = ROM_AW - 8;
  localparam int STK_N = 1 << SP_W;

  generate
    if (ROM_AW < 11 || ROM_AW > 12 || SP_W < 1 || SP_W > 4)
    begin : g_bad_param
      $error("bcte_core: ROM_AW must be 11..12 and SP_W 1..4");
    end
  endgenerate

  bcte_state_t state_r;
  bcte_op_t op;
  logic [ROM_AW-1:0] pc_r;
  logic [ROM_AW-1:0] ret_stk_r [0:STK_N-1];
  logic [SP_W-1:0] sp_r;
  logic [3:0] acc_r;
  logic carry_r;
  logic flag_r;
  logic [3:0] page_r;
  logic [9:0] timer_r;
  logic [9:0] timer_nxt;
  logic [9:0] mod_a_r;
  logic [9:0] mod_b_r;
  logic [3:0] gr_r [0:31];
  logic [3:0] halt_cond_r;
  logic standby_r;
  logic rst_evt_r;
  logic tmr_evt_r;
  logic tmr_run_r;
  logic [15:0] tcnt_r;
  logic [ROM_AW-1:0] rom_ptr_r;
  logic [9:0] w1_r;
  logic [9:0] w2_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_mux;
  logic core_rst_r;
  logic tmr_fire_r;

  logic exe;
  logic bus_wr;
  logic rom_stall;
  logic step_go;
  logic two_word;
  logic jpage;
  logic nib_hi;
  logic int_rst;
  logic tload;
  logic tmr_fire;
  logic greg_hit;
  logic [7:0] goff;
  logic [4:0] gidx;
  logic [9:0] imm10;
  logic [9:0] tab_word;
  logic [7:0] pair_val;
  logic [ROM_AW-1:0] jtgt;
  logic [ROM_AW-1:0] pc_seq;
  logic [ROM_AW-1:0] tab_addr;
  logic [SP_W-1:0] sp_inc;

  bcte_rom_if #(.AW(ROM_AW)) rom_bus();

  bcte_rom #(.AW(ROM_AW)) u_rom (
    .clk_i(clk_i),
    .rom(rom_bus.mem)
  );

  function automatic logic [15:0] tmr_reload(input logic [9:0] v);
    logic [16:0] p;
    p = ({7'h00, v} + 17'h0_0001) * `BCTE_TMR_MUL - `BCTE_TMR_TRIM;
    return p[15:0] - 16'h0001;
  endfunction : tmr_reload

  assign exe = (state_r == S_EXE);
  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign rom_stall = wb_we_i && (wb_adr_i == `BCTE_ADR_ROM_DATA) &&
    (state_r != S_IDLE);
  assign step_go = bus_wr && (wb_adr_i == `BCTE_ADR_CTRL) && wb_sel_i[0] &&
    wb_dat_i[`BCTE_CTRL_STEP] && (state_r == S_IDLE) && !standby_r;
  assign goff = wb_adr_i - `BCTE_ADR_GREG_LO;
  assign gidx = goff[6:2];
  assign greg_hit = (wb_adr_i >= `BCTE_ADR_GREG_LO) &&
    (wb_adr_i <= `BCTE_ADR_GREG_HI) && (wb_adr_i[1:0] == 2'h0);
  assign nib_hi = w1_r[5];
  // RQ18 timer field order
  assign imm10 = {w2_r[8:5], w2_r[3:0], w2_r[9], w2_r[4]};
  assign tab_word = rom_bus.rdata;
  // RQ9 target bit order
  assign jtgt = ROM_AW'({jpage, w2_r[9], w2_r[4], w2_r[8:5], w2_r[3:0]});
  assign pc_seq = pc_r + (two_word ? ROM_AW'(2) : ROM_AW'(1));
  // RQ3 page plus pointer
  assign tab_addr = {page_r[PG_W-1:0], gr_r[16], gr_r[0]};
  assign sp_inc = sp_r + 1'b1;
  // RQ11 RQ13 stack faults
  assign int_rst = exe && (((op == OP_CALL) && (&sp_r)) ||
    ((op == OP_RTN) && (sp_r == '0)));
  assign tmr_fire = tmr_run_r && (tcnt_r == 16'h0000);

  // RQ4 page 0 or 1
  always_comb
  begin
    op = OP_NONE;
    jpage = (w1_r == `BCTE_OP_JCS_P1) || (w1_r == `BCTE_OP_JCC_P1) ||
      (w1_r == `BCTE_OP_JFS_P1) || (w1_r == `BCTE_OP_JFC_P1) ||
      (w1_r == `BCTE_OP_CALL_P1);
    if (w1_r == `BCTE_OP_JCS_P0 || w1_r == `BCTE_OP_JCS_P1) op = OP_JCS;
    else if (w1_r == `BCTE_OP_JCC_P0 || w1_r == `BCTE_OP_JCC_P1) op = OP_JCC;
    else if (w1_r == `BCTE_OP_JFS_P0 || w1_r == `BCTE_OP_JFS_P1) op = OP_JFS;
    else if (w1_r == `BCTE_OP_JFC_P0 || w1_r == `BCTE_OP_JFC_P1) op = OP_JFC;
    else if (w1_r == `BCTE_OP_CALL_P0 || w1_r == `BCTE_OP_CALL_P1)
      op = OP_CALL;
    else if (w1_r == `BCTE_OP_RTN) op = OP_RTN;
    else if (w1_r == `BCTE_OP_LD_TMR_IMM) op = OP_LD_TMR_IMM;
    else if (w1_r == `BCTE_OP_LD_MA_IMM) op = OP_LD_MA_IMM;
    else if (w1_r == `BCTE_OP_LD_MB_IMM) op = OP_LD_MB_IMM;
    else if (w1_r == `BCTE_OP_LD_TMR_TAB) op = OP_LD_TMR_TAB;
    else if (w1_r == `BCTE_OP_LD_MA_TAB) op = OP_LD_MA_TAB;
    else if (w1_r == `BCTE_OP_LD_MB_TAB) op = OP_LD_MB_TAB;
    else if (w1_r == `BCTE_OP_HALT) op = OP_HALT;
    else if ((w1_r & `BCTE_NIB_MASK) == `BCTE_OP_RD_TMR) op = OP_RD_TMR;
    else if ((w1_r & `BCTE_NIB_MASK) == `BCTE_OP_RD_MA) op = OP_RD_MA;
    else if ((w1_r & `BCTE_NIB_MASK) == `BCTE_OP_RD_MB) op = OP_RD_MB;
    else if ((w1_r & `BCTE_NIB_MASK) == `BCTE_OP_WR_TMR) op = OP_WR_TMR;
    else if ((w1_r & `BCTE_NIB_MASK) == `BCTE_OP_WR_MA) op = OP_WR_MA;
    else if ((w1_r & `BCTE_NIB_MASK) == `BCTE_OP_WR_MB) op = OP_WR_MB;
    else if (w1_r[9:4] == `BCTE_PFX_PAIR_IMM) op = OP_PAIR_IMM;
    else if (w1_r[9:4] == `BCTE_PFX_PAIR_TAB) op = OP_PAIR_TAB;
    two_word = (op == OP_JCS) || (op == OP_JCC) || (op == OP_JFS) ||
      (op == OP_JFC) || (op == OP_CALL) || (op == OP_PAIR_IMM) ||
      (op == OP_LD_TMR_IMM) || (op == OP_LD_MA_IMM) ||
      (op == OP_LD_MB_IMM) || (op == OP_HALT);
  end

  // RQ23 one step per instruction
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= S_IDLE;
    else
    begin
      case (state_r)
        S_IDLE: if (step_go) state_r <= S_W1;
        S_W1: state_r <= S_W2;
        S_W2: state_r <= S_TAB;
        S_TAB: state_r <= S_EXE;
        S_EXE: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Fetch words arrive one cycle after their address.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      w1_r <= 10'h000;
      w2_r <= 10'h000;
    end
    else if (state_r == S_W2)
      w1_r <= rom_bus.rdata;
    else if (state_r == S_TAB)
      w2_r <= rom_bus.rdata;
  end

  always_comb
  begin
    rom_bus.we = 1'b0;
    rom_bus.wdata = wb_dat_i[9:0];
    rom_bus.addr = pc_r;
    if (bus_wr && wb_adr_i == `BCTE_ADR_ROM_DATA)
    begin
      rom_bus.we = 1'b1;
      rom_bus.addr = rom_ptr_r;
    end
    else if (state_r == S_W2)
      rom_bus.addr = pc_r + ROM_AW'(1);
    else if (state_r == S_TAB)
      rom_bus.addr = tab_addr;
  end

  // RQ5 RQ6 RQ7 RQ8 conditional jumps
  always_ff @(posedge clk_i)
  begin
    if (rst_i || int_rst)
      pc_r <= '0;
    else if (exe)
    begin
      case (op)
        OP_JCS: pc_r <= carry_r ? jtgt : pc_seq;
        OP_JCC: pc_r <= !carry_r ? jtgt : pc_seq;
        OP_JFS: pc_r <= flag_r ? jtgt : pc_seq;
        OP_JFC: pc_r <= !flag_r ? jtgt : pc_seq;
        OP_CALL: pc_r <= jtgt;
        // RQ12 restore return address
        OP_RTN: pc_r <= ret_stk_r[sp_r];
        default: pc_r <= pc_seq;
      endcase
    end
    else if (bus_wr && wb_adr_i == `BCTE_ADR_PC)
    begin
      if (wb_sel_i[0]) pc_r[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) pc_r[ROM_AW-1:8] <= wb_dat_i[ROM_AW-1:8];
    end
  end

  // RQ10 push return address
  always_ff @(posedge clk_i)
  begin
    if (rst_i || int_rst)
      sp_r <= '0;
    else if (exe && op == OP_CALL)
    begin
      sp_r <= sp_inc;
      ret_stk_r[sp_inc] <= pc_seq;
    end
    else if (exe && op == OP_RTN)
      sp_r <= sp_r - 1'b1;
  end

  // RQ15 RQ17 carry cleared
  always_ff @(posedge clk_i)
  begin
    if (rst_i || int_rst)
      carry_r <= 1'b0;
    else if (exe && (op == OP_RD_MA || op == OP_RD_MB ||
        op == OP_WR_MA || op == OP_WR_MB))
      carry_r <= 1'b0;
    else if (bus_wr && wb_adr_i == `BCTE_ADR_FLAGS && wb_sel_i[0])
      carry_r <= wb_dat_i[`BCTE_FL_CARRY];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || int_rst)
      flag_r <= 1'b0;
    else if (bus_wr && wb_adr_i == `BCTE_ADR_FLAGS && wb_sel_i[0])
      flag_r <= wb_dat_i[`BCTE_FL_STATUS];
  end

  // RQ14 RQ15 nibble reads
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      acc_r <= 4'h0;
    else if (exe && op == OP_RD_TMR)
      acc_r <= nib_hi ? timer_r[9:6] : timer_r[5:2];
    else if (exe && op == OP_RD_MA)
      acc_r <= nib_hi ? mod_a_r[9:6] : mod_a_r[5:2];
    else if (exe && op == OP_RD_MB)
      acc_r <= nib_hi ? mod_b_r[9:6] : mod_b_r[5:2];
    else if (bus_wr && wb_adr_i == `BCTE_ADR_ACC && wb_sel_i[0])
      acc_r <= wb_dat_i[3:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      page_r <= 4'h0;
    else if (bus_wr && wb_adr_i == `BCTE_ADR_PAGE && wb_sel_i[0])
      page_r <= wb_dat_i[3:0];
  end

  // RQ1 RQ2 pair writes
  assign pair_val = (op == OP_PAIR_TAB) ? {tab_word[8:5], tab_word[3:0]} :
    {w2_r[8:5], w2_r[3:0]};

  generate
    for (genvar i = 0; i < 32; i++)
    begin : g_greg
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          gr_r[i] <= 4'h0;
        else if (exe && (op == OP_PAIR_IMM || op == OP_PAIR_TAB) &&
            (w1_r[3:0] == 4'(i % 16)))
          gr_r[i] <= (i >= 16) ? pair_val[7:4] : pair_val[3:0];
        else if (bus_wr && greg_hit && gidx == 5'(i) && wb_sel_i[0])
          gr_r[i] <= wb_dat_i[3:0];
      end
    end
  endgenerate

  // RQ16 timer nibble writes
  always_comb
  begin
    timer_nxt = timer_r;
    tload = 1'b0;
    if (exe && op == OP_WR_TMR)
    begin
      tload = 1'b1;
      if (nib_hi) timer_nxt = {acc_r, timer_r[5:2], 1'b0, timer_r[0]};
      else timer_nxt = {timer_r[9:6], acc_r, timer_r[1], 1'b0};
    end
    else if (exe && op == OP_LD_TMR_IMM)
    begin
      tload = 1'b1;
      timer_nxt = imm10;
    end
    // RQ21 timer table load
    else if (exe && op == OP_LD_TMR_TAB)
    begin
      tload = 1'b1;
      timer_nxt = tab_word;
    end
    else if (bus_wr && wb_adr_i == `BCTE_ADR_TIMER)
    begin
      tload = wb_sel_i[0] | wb_sel_i[1];
      if (wb_sel_i[0]) timer_nxt[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) timer_nxt[9:8] = wb_dat_i[9:8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer_r <= 10'h000;
    else if (tload)
      timer_r <= timer_nxt;
  end

  // RQ19 interval count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tcnt_r <= 16'h0000;
      tmr_run_r <= 1'b0;
    end
    else if (tload)
    begin
      tcnt_r <= tmr_reload(timer_nxt);
      tmr_run_r <= 1'b1;
    end
    else if (tmr_fire)
      tcnt_r <= tmr_reload(timer_r);
    else if (tmr_run_r)
      tcnt_r <= tcnt_r - 16'h0001;
  end

  // RQ17 RQ20 RQ21 modulo loads
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mod_a_r <= 10'h000;
    else if (exe && op == OP_WR_MA)
      mod_a_r <= nib_hi ? {acc_r, mod_a_r[5:2], 1'b0, mod_a_r[0]} :
        {mod_a_r[9:6], acc_r, mod_a_r[1], 1'b0};
    else if (exe && op == OP_LD_MA_IMM)
      mod_a_r <= imm10;
    else if (exe && op == OP_LD_MA_TAB)
      mod_a_r <= tab_word;
    else if (bus_wr && wb_adr_i == `BCTE_ADR_MOD_A && wb_sel_i[0])
      mod_a_r <= wb_dat_i[9:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mod_b_r <= 10'h000;
    else if (exe && op == OP_WR_MB)
      mod_b_r <= nib_hi ? {acc_r, mod_b_r[5:2], 1'b0, mod_b_r[0]} :
        {mod_b_r[9:6], acc_r, mod_b_r[1], 1'b0};
    else if (exe && op == OP_LD_MB_IMM)
      mod_b_r <= imm10;
    else if (exe && op == OP_LD_MB_TAB)
      mod_b_r <= tab_word;
    else if (bus_wr && wb_adr_i == `BCTE_ADR_MOD_B && wb_sel_i[0])
      mod_b_r <= wb_dat_i[9:0];
  end

  // RQ22 standby and release
  always_ff @(posedge clk_i)
  begin
    if (rst_i || int_rst)
    begin
      standby_r <= 1'b0;
      halt_cond_r <= 4'h0;
    end
    else if (exe && op == OP_HALT)
    begin
      standby_r <= 1'b1;
      halt_cond_r <= w2_r[3:0];
    end
    else if (standby_r && |(halt_cond_r & {wake_i, tmr_fire}))
      standby_r <= 1'b0;
  end

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rst_evt_r <= 1'b0;
      tmr_evt_r <= 1'b0;
    end
    else
    begin
      if (int_rst)
        rst_evt_r <= 1'b1;
      else if (bus_wr && wb_adr_i == `BCTE_ADR_STATUS && wb_sel_i[0] &&
          wb_dat_i[`BCTE_ST_RST_EVT])
        rst_evt_r <= 1'b0;
      if (tmr_fire)
        tmr_evt_r <= 1'b1;
      else if (bus_wr && wb_adr_i == `BCTE_ADR_STATUS && wb_sel_i[0] &&
          wb_dat_i[`BCTE_ST_TMR_EVT])
        tmr_evt_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rom_ptr_r <= '0;
    else if (bus_wr && wb_adr_i == `BCTE_ADR_ROM_DATA)
      rom_ptr_r <= rom_ptr_r + ROM_AW'(1);
    else if (bus_wr && wb_adr_i == `BCTE_ADR_ROM_PTR && wb_sel_i[0])
      rom_ptr_r <= wb_dat_i[ROM_AW-1:0];
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (wb_adr_i == `BCTE_ADR_CTRL)
      rd_mux[`BCTE_CTRL_STEP] = (state_r != S_IDLE);
    else if (wb_adr_i == `BCTE_ADR_STATUS)
      rd_mux[3:0] = {tmr_evt_r, rst_evt_r, standby_r, state_r != S_IDLE};
    else if (wb_adr_i == `BCTE_ADR_FLAGS)
      rd_mux[1:0] = {flag_r, carry_r};
    else if (wb_adr_i == `BCTE_ADR_PC)
      rd_mux[ROM_AW-1:0] = pc_r;
    else if (wb_adr_i == `BCTE_ADR_ACC)
      rd_mux[3:0] = acc_r;
    else if (wb_adr_i == `BCTE_ADR_PAGE)
      rd_mux[3:0] = page_r;
    else if (wb_adr_i == `BCTE_ADR_SP)
      rd_mux[SP_W-1:0] = sp_r;
    else if (wb_adr_i == `BCTE_ADR_TIMER)
      rd_mux[9:0] = timer_r;
    else if (wb_adr_i == `BCTE_ADR_MOD_A)
      rd_mux[9:0] = mod_a_r;
    else if (wb_adr_i == `BCTE_ADR_MOD_B)
      rd_mux[9:0] = mod_b_r;
    else if (wb_adr_i == `BCTE_ADR_HALT)
      rd_mux[3:0] = halt_cond_r;
    else if (wb_adr_i == `BCTE_ADR_ROM_PTR)
      rd_mux[ROM_AW-1:0] = rom_ptr_r;
    else if (greg_hit)
      rd_mux[3:0] = gr_r[gidx];
  end

  // Code writes wait for idle so a fetch never reads a half-written word.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r & ~rom_stall;
      if (wb_cyc_i & wb_stb_i & ~ack_r)
        dat_r <= rd_mux;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      core_rst_r <= 1'b0;
      tmr_fire_r <= 1'b0;
    end
    else
    begin
      core_rst_r <= int_rst;
      tmr_fire_r <= tmr_fire;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign standby_o = standby_r;
  assign timer_evt_o = tmr_fire_r;
  assign core_reset_o = core_rst_r;
endmodule : bcte_core
`default_nettype wire

// *** bcte_defines.svh ***
`ifndef BCTE_DEFINES_SVH
`define BCTE_DEFINES_SVH

`define BCTE_ADR_CTRL 8'h00
`define BCTE_ADR_STATUS 8'h04
`define BCTE_ADR_FLAGS 8'h08
`define BCTE_ADR_PC 8'h0C
`define BCTE_ADR_ACC 8'h10
`define BCTE_ADR_PAGE 8'h14
`define BCTE_ADR_SP 8'h18
`define BCTE_ADR_TIMER 8'h1C
`define BCTE_ADR_MOD_A 8'h20
`define BCTE_ADR_MOD_B 8'h24
`define BCTE_ADR_HALT 8'h28
`define BCTE_ADR_ROM_PTR 8'h2C
`define BCTE_ADR_ROM_DATA 8'h30
`define BCTE_ADR_GREG_LO 8'h40
`define BCTE_ADR_GREG_HI 8'hBC

`define BCTE_ST_BUSY 0
`define BCTE_ST_STANDBY 1
`define BCTE_ST_RST_EVT 2
`define BCTE_ST_TMR_EVT 3
`define BCTE_FL_CARRY 0
`define BCTE_FL_STATUS 1
`define BCTE_CTRL_STEP 0

`define BCTE_OP_JCS_P0 10'h191
`define BCTE_OP_JCS_P1 10'h151
`define BCTE_OP_JCC_P0 10'h1B1
`define BCTE_OP_JCC_P1 10'h171
`define BCTE_OP_JFS_P0 10'h1D1
`define BCTE_OP_JFS_P1 10'h211
`define BCTE_OP_JFC_P0 10'h1F1
`define BCTE_OP_JFC_P1 10'h231
`define BCTE_OP_CALL_P0 10'h0D1
`define BCTE_OP_CALL_P1 10'h091
`define BCTE_OP_RTN 10'h112
`define BCTE_PFX_PAIR_IMM 6'h03
`define BCTE_PFX_PAIR_TAB 6'h0E
`define BCTE_NIB_MASK 10'h3DF
`define BCTE_OP_RD_TMR 10'h3DF
`define BCTE_OP_RD_MA 10'h3D6
`define BCTE_OP_RD_MB 10'h3D7
`define BCTE_OP_WR_TMR 10'h09F
`define BCTE_OP_WR_MA 10'h096
`define BCTE_OP_WR_MB 10'h097
`define BCTE_OP_LD_TMR_IMM 10'h0DF
`define BCTE_OP_LD_MA_IMM 10'h0D6
`define BCTE_OP_LD_MB_IMM 10'h0D7
`define BCTE_OP_LD_TMR_TAB 10'h0FF
`define BCTE_OP_LD_MA_TAB 10'h0F6
`define BCTE_OP_LD_MB_TAB 10'h0F7
`define BCTE_OP_HALT 10'h0A1

`define BCTE_TMR_MUL 17'h0_0040
`define BCTE_TMR_TRIM 17'h0_0004

`endif

// *** bcte_pkg.sv ***
`default_nettype none
package bcte_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_W1 = 5'b00010,
    S_W2 = 5'b00100,
    S_TAB = 5'b01000,
    S_EXE = 5'b10000
  } bcte_state_t;

  typedef enum logic [4:0] {
    OP_NONE, OP_PAIR_IMM, OP_PAIR_TAB, OP_JCS, OP_JCC, OP_JFS, OP_JFC,
    OP_CALL, OP_RTN, OP_RD_TMR, OP_RD_MA, OP_RD_MB, OP_WR_TMR, OP_WR_MA,
    OP_WR_MB, OP_LD_TMR_IMM, OP_LD_MA_IMM, OP_LD_MB_IMM, OP_LD_TMR_TAB,
    OP_LD_MA_TAB, OP_LD_MB_TAB, OP_HALT
  } bcte_op_t;
endpackage : bcte_pkg
`default_nettype wire

// *** bcte_rom_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface bcte_rom_if #(
  parameter int AW = 11
);
  logic [AW-1:0] addr;
  logic [9:0] wdata;
  logic we;
  logic [9:0] rdata;
  modport ctrl(output addr, output wdata, output we, input rdata);
  modport mem(input addr, input wdata, input we, output rdata);
endinterface : bcte_rom_if
`default_nettype wire

// *** bcte_rom.sv ***
`timescale 1ns/1ps
`default_nettype none
module bcte_rom #(
  parameter int AW = 11
)(
  input wire logic clk_i,
  bcte_rom_if.mem rom
);
  // Read is registered so the array maps onto block memory.
  logic [9:0] mem_r [0:(1<<AW)-1];

  always_ff @(posedge clk_i)
  begin
    if (rom.we)
    begin
      mem_r[rom.addr] <= rom.wdata;
    end
    rom.rdata <= mem_r[rom.addr];
  end
endmodule : bcte_rom
`default_nettype wire

// *** bcte_wake_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bcte_wake_model (
  input wire logic clk_i,
  input wire logic [2:0] req_i,
  output logic [2:0] wake_o
);
  // wake release sources
  // Sources settle one clock late, as a synchronised pin would.
  always_ff @(posedge clk_i)
  begin
    wake_o <= req_i;
  end
endmodule : bcte_wake_model
`default_nettype wire

// *** bcte_core_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module bcte_core_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic standby_o,
  input wire logic timer_evt_o,
  input wire logic core_reset_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_CAUSE: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  AST_ACK_BOUND: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:7] wb_ack_o)
    else $error("request not answered in time");
  AST_UNMAP_ZERO: assert property (
    wb_ack_o && !wb_we_i && (wb_adr_i[1:0] != 2'h0 || wb_adr_i > 8'hbc
    || (wb_adr_i > 8'h30 && wb_adr_i < 8'h40)) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_DAT_HOLD: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved outside an answer");
  AST_RST_PULSE: assert property (core_reset_o |=> !core_reset_o)
    else $error("internal reset pulse too long");
  // A stack fault can only come from the execute cycle of an accepted step.
  AST_RST_CAUSE: assert property (
    core_reset_o |-> $past(wb_ack_o && wb_we_i && wb_adr_i == 8'h00, 5))
    else $error("internal reset without a step five cycles before");
  // Shortest interval is value 0: 60 clocks, so 8 quiet cycles must hold.
  AST_TMR_GAP: assert property (
    timer_evt_o |=> !timer_evt_o [*8])
    else $error("timer events too close");
endmodule : bcte_core_monitor
bind bcte_core bcte_core_monitor u_bcte_core_monitor (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .standby_o, .timer_evt_o, .core_reset_o);
`default_nettype wire

// *** bcte_core_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bcte_defines.svh"
module bcte_core_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rd;
  logic [31:0] q;
  logic ack;
  logic stby;
  logic tevt;
  logic crst;
  logic [2:0] wake;
  logic [2:0] wreq = 3'h0;
  int errors = 0;
  int n_tests = 0;
  int ncyc = 0;
  int ncrst = 0;
  initial forever #12.5 clk_i = ~clk_i;
  // Strobe rides on cycle: classic single accesses only.
  bcte_core u_bcte_core (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .wake_i(wake), .standby_o(stby),
    .timer_evt_o(tevt), .core_reset_o(crst));
  bcte_wake_model u_bcte_wake_model (.clk_i, .req_i(wreq), .wake_o(wake));
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  always @(posedge clk_i)
  begin
    ncyc <= ncyc + 1;
    if (crst === 1'b1)
      ncrst <= ncrst + 1;
    if (ncyc == 8000)
    begin
      errors = errors + 1;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i);
    while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
  endtask : wb
  task automatic chkr(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask : chkr
  task automatic run(input logic [10:0] pc, input logic [9:0] w0,
                     input logic [9:0] w1);
    wb(1'b1, `BCTE_ADR_ROM_PTR, {21'h0, pc});
    wb(1'b1, `BCTE_ADR_ROM_DATA, {22'h0, w0});
    wb(1'b1, `BCTE_ADR_ROM_DATA, {22'h0, w1});
    wb(1'b1, `BCTE_ADR_PC, {21'h0, pc});
    wb(1'b1, `BCTE_ADR_CTRL, 32'h1);
    repeat (8)
    begin
      wb(1'b0, `BCTE_ADR_STATUS, 32'h0);
      if (q[0] === 1'b0)
        break;
    end
  endtask : run
  function automatic logic [9:0] ja(input logic [9:0] a);
    return {a[9], a[7:4], a[8], a[3:0]};
  endfunction : ja
  function automatic logic [9:0] tv(input logic [9:0] t);
    return {t[1], t[9:6], t[0], t[5:2]};
  endfunction : tv
  task automatic t_jump;
    logic [9:0] op [4];
    logic [10:0] pc;
    logic [1:0] fl;
    logic tk;
    op = '{`BCTE_OP_JCS_P0, `BCTE_OP_JCC_P0, `BCTE_OP_JFS_P0,
           `BCTE_OP_JFC_P0};
    for (int i = 0; i < 4; i++)
    begin
      for (int f = 0; f < 2; f++)
      begin
        pc = 11'h010 + 11'(8 * i + 2 * f);
        fl = (i < 2) ? 2'(f) : 2'(2 * f);
        tk = f[0] ^ i[0];
        wb(1'b1, `BCTE_ADR_FLAGS, {30'h0, fl});
        run(pc, op[i], ja(10'h2a5));
        chkr("jump pc", `BCTE_ADR_PC,
             tk ? 32'h2a5 : {21'h0, pc + 11'h2});
        chkr("flags", `BCTE_ADR_FLAGS, {30'h0, fl});
      end
    end
    wb(1'b1, `BCTE_ADR_FLAGS, 32'h1);
    run(11'h060, `BCTE_OP_JCS_P1, ja(10'h2a5));
    chkr("page1 pc", `BCTE_ADR_PC, 32'h6a5);
  endtask : t_jump
  task automatic t_pair;
    logic [9:0] tw;
    tw = 10'h2b7;
    run(11'h080, {6'h03, 4'h5}, {1'b0, 4'hc, 1'b0, 4'h3});
    chkr("imm lo", `BCTE_ADR_GREG_LO + 8'h14, 32'h3);
    chkr("imm hi", `BCTE_ADR_GREG_LO + 8'h54, 32'hc);
    wb(1'b1, `BCTE_ADR_PAGE, 32'h5);
    wb(1'b1, `BCTE_ADR_GREG_LO, 32'hc);
    wb(1'b1, `BCTE_ADR_GREG_LO + 8'h40, 32'h3);
    wb(1'b1, `BCTE_ADR_ROM_PTR, 32'h53c);
    wb(1'b1, `BCTE_ADR_ROM_DATA, {22'h0, tw});
    run(11'h090, {6'h0e, 4'h7}, 10'h000);
    chkr("tab lo", `BCTE_ADR_GREG_LO + 8'h1c, {28'h0, tw[3:0]});
    chkr("tab hi", `BCTE_ADR_GREG_LO + 8'h5c, {28'h0, tw[8:5]});
    run(11'h0a0, `BCTE_OP_LD_MB_TAB, 10'h000);
    chkr("tab mod", `BCTE_ADR_MOD_B, {22'h0, tw});
  endtask : t_pair
  task automatic t_call;
    run(11'h100, `BCTE_OP_CALL_P0, ja(10'h123));
    chkr("call pc", `BCTE_ADR_PC, 32'h123);
    chkr("call sp", `BCTE_ADR_SP, 32'h1);
    run(11'h123, `BCTE_OP_RTN, 10'h000);
    chkr("ret pc", `BCTE_ADR_PC, 32'h102);
    chkr("ret sp", `BCTE_ADR_SP, 32'h0);
    run(11'h130, `BCTE_OP_RTN, 10'h000);
    chk("underflow", 32'h1, 32'(ncrst));
    chkr("reset pc", `BCTE_ADR_PC, 32'h0);
    run(11'h100, `BCTE_OP_CALL_P0, ja(10'h123));
    run(11'h123, `BCTE_OP_CALL_P1, ja(10'h040));
    chk("overflow", 32'h2, 32'(ncrst));
  endtask : t_call
  task automatic t_mod;
    wb(1'b1, `BCTE_ADR_MOD_A, 32'h3a5);
    wb(1'b1, `BCTE_ADR_FLAGS, 32'h1);
    run(11'h140, `BCTE_OP_RD_MA, 10'h000);
    chkr("rd lo", `BCTE_ADR_ACC, 32'h9);
    chkr("rd carry", `BCTE_ADR_FLAGS, 32'h0);
    run(11'h142, `BCTE_OP_RD_MA | 10'h020, 10'h000);
    chkr("rd hi", `BCTE_ADR_ACC, 32'he);
    wb(1'b1, `BCTE_ADR_ACC, 32'h6);
    wb(1'b1, `BCTE_ADR_FLAGS, 32'h1);
    run(11'h150, `BCTE_OP_WR_MA | 10'h020, 10'h000);
    chkr("wr hi", `BCTE_ADR_MOD_A, 32'h1a5);
    chkr("wr carry", `BCTE_ADR_FLAGS, 32'h0);
    run(11'h152, `BCTE_OP_WR_MA, 10'h000);
    chkr("wr lo", `BCTE_ADR_MOD_A, 32'h198);
    run(11'h154, `BCTE_OP_LD_MB_IMM, tv(10'h26b));
    chkr("imm mod", `BCTE_ADR_MOD_B, 32'h26b);
  endtask : t_mod
  task automatic t_timer;
    int n;
    run(11'h160, `BCTE_OP_LD_TMR_IMM, tv(10'h002));
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do
      begin
        @(posedge clk_i);
        n++;
      end
      while (tevt !== 1'b1 && n < 400);
    end
    chk("tmr gap", 32'((2 + 1) * 64 - 4), 32'(n));
    wb(1'b1, `BCTE_ADR_ACC, 32'ha);
    run(11'h164, `BCTE_OP_WR_TMR | 10'h020, 10'h000);
    chkr("wr tmr", `BCTE_ADR_TIMER, 32'h280);
    wb(1'b1, `BCTE_ADR_ACC, 32'h0);
    run(11'h166, `BCTE_OP_RD_TMR | 10'h020, 10'h000);
    chkr("rd tmr", `BCTE_ADR_ACC, 32'ha);
  endtask : t_timer
  task automatic t_halt;
    run(11'h170, `BCTE_OP_HALT, 10'h002);
    chk("standby", 32'h1, {31'h0, stby});
    repeat (20) @(posedge clk_i);
    chk("held", 32'h1, {31'h0, stby});
    wreq <= 3'h1;
    repeat (20)
    begin
      @(posedge clk_i);
      if (stby === 1'b0)
        break;
    end
    chk("woken", 32'h0, {31'h0, stby});
    wreq <= 3'h0;
  endtask : t_halt
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    chkr("rst pc", `BCTE_ADR_PC, 32'h0);
    wb(1'b1, 8'h34, 32'hffff_ffff);
    chkr("unmapped", 8'h34, 32'h0);
    t_jump();
    t_pair();
    t_call();
    t_mod();
    t_timer();
    t_halt();
    stop_test();
  end
endmodule : bcte_core_tb_top
`default_nettype wire
